/* File: src/apmc_top.sv */
/*
  Power mode sequencer and input/supply alarm of a sampling converter,
  with a classic Wishbone register slave.
  Assumes the convert/select pin and the converter core signals are
  synchronous to I_CLK, and that the host respects the wake-up times.
*/
// Chosen here: the Wishbone register port and the placing of the registers.
// Notes on behaviour
// (R1) In normal mode the analog blocks stay powered between conversions.
// (R2) Power control changes are accepted only after the key 69h is written to index 05h.
// (R3) With light sleep enabled and the pin high at end of conversion, light sleep is held while the pin stays high.
// (R4) A falling edge of the convert/select pin ends light sleep.
// (R5) The host waits the light sleep wake time before the next conversion edge.
// (R6) With the deep sleep request set, the next rising pin edge enters deep sleep.
// (R7) Deep sleep powers the analog blocks down while the bus and all registers keep working.
// (R8) The ready indicator is high during deep sleep.
// (R9) The host leaves deep sleep by writing zero to the deep sleep request bit.
// (R10) Clearing the request drives the ready indicator high as power-up begins.
// (R11) The host waits the deep sleep wake time before starting a conversion.
// (R12) The input alarm trips when a result lies outside the low and high thresholds.
// (R13) The input alarm uses a programmable hysteresis.
// (R14) A separate alarm watches the analog supply.
// (R15) The hysteresis is the six upper bits of its byte, the two lowest bits held at zero.
// (R16) The overall alarm bit is the OR of all tripped flags.
// (R17) A high alarm clears below high minus hysteresis, a low alarm above low plus hysteresis.
`include "apmc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module apmc_top #(
  parameter int unsigned DEEP_WAKE_CYC = `APMC_DEEP_WAKE_CYC
) (
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [9:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Host pin and converter core
  input wire logic I_CONVERT_SELECT,
  input wire logic I_CONV_DONE,
  input wire logic [15:0] I_RESULT,
  input wire logic I_SUPPLY_LOW,
  input wire logic I_SUPPLY_HIGH,
  // Power and status outputs
  output logic O_CONV_START,
  output logic O_ANALOG_PWR_EN,
  output logic O_LOW_POWER,
  output logic O_READY_IND,
  output logic O_ALARM
);

  // =====================================================================
  // Helpers
  function automatic logic [16:0] sat_add(input logic [15:0] a, input logic [5:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {11'h000, b};
    sat_add = s[16] ? 17'h0_FFFF : s;
  endfunction

  function automatic logic [16:0] sat_sub(input logic [15:0] a, input logic [5:0] b);
    sat_sub = (a < {10'h000, b}) ? 17'h0_0000 : {1'b0, a - {10'h000, b}};
  endfunction

  localparam logic [7:0] LIGHT_WAKE_CYC = 8'(`APMC_LIGHT_WAKE_CYC);

  // =====================================================================
  // Registers
  apmc_pkg::apmc_state_e state_ff;
  apmc_pkg::apmc_state_e nxt_state;
  apmc_pkg::apmc_flags_s active_ff;
  apmc_pkg::apmc_flags_s trip_ff;
  logic unlock_ff;
  logic deep_req_ff;
  logic light_en_ff;
  logic [15:0] high_th_ff;
  logic [15:0] low_th_ff;
  logic [5:0] hyst_ff;
  logic pin_prev_ff;
  logic [23:0] wait_ff;
  logic [31:0] rdata;

  wire logic bus_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire logic bus_wr = bus_req & I_WB_WE;
  wire logic [7:0] bus_idx = I_WB_ADR[9:2];
  wire logic pin_rise = I_CONVERT_SELECT & ~pin_prev_ff;
  wire logic pin_fall = ~I_CONVERT_SELECT & pin_prev_ff;
  wire logic pwr_wr = bus_wr & I_WB_SEL[0] & unlock_ff & (bus_idx == `APMC_IDX_PWRCTL);
  wire logic stat_rd = bus_req & ~I_WB_WE & (bus_idx == `APMC_IDX_STATUS);

  // =====================================================================
  // Wishbone answer: one cycle after the strobe, unmapped reads give zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (bus_idx)
      `APMC_IDX_PWRCTL:
      begin
        rdata[`APMC_PWR_DEEP_BIT] = deep_req_ff;
        rdata[`APMC_PWR_LIGHT_BIT] = light_en_ff;
      end
      `APMC_IDX_UNLOCK: rdata[0] = unlock_ff;
      `APMC_IDX_STATUS:
      begin
        // (R16) overall alarm
        rdata[0] = |trip_ff;
        rdata[7:4] = trip_ff;
        rdata[11:10] = {active_ff.in_low, active_ff.in_high};
        rdata[15:14] = {active_ff.sup_low, active_ff.sup_high};
      end
      // (R15) low hysteresis bits read zero
      `APMC_IDX_ALARM_H_TH: rdata = {hyst_ff, 2'b00, 8'h00, high_th_ff};
      `APMC_IDX_ALARM_L_TH: rdata = {16'h0000, low_th_ff};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end
    else if (I_CE)
    begin
      O_WB_ACK <= bus_req;
      O_WB_DAT <= bus_req ? rdata : 32'h0000_0000;
    end
  end

  // =====================================================================
  // Unlock key: stays open until some other value is written
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      unlock_ff <= 1'b0;
    // (R2) key write opens
    else if (I_CE && bus_wr && I_WB_SEL[0] && bus_idx == `APMC_IDX_UNLOCK)
      unlock_ff <= (I_WB_DAT[7:0] == `APMC_UNLOCK_KEY);
  end

  // =====================================================================
  // Power control bits
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      deep_req_ff <= 1'b0;
      light_en_ff <= 1'b0;
    end
    // (R2) locked writes ignored
    else if (I_CE && pwr_wr)
    begin
      deep_req_ff <= I_WB_DAT[`APMC_PWR_DEEP_BIT];
      light_en_ff <= I_WB_DAT[`APMC_PWR_LIGHT_BIT];
    end
  end

  // =====================================================================
  // Alarm thresholds and hysteresis, with byte enables
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      high_th_ff <= `APMC_RST_HIGH_TH;
      low_th_ff <= `APMC_RST_LOW_TH;
      hyst_ff <= `APMC_RST_HYST;
    end
    else if (I_CE && bus_wr && bus_idx == `APMC_IDX_ALARM_H_TH)
    begin
      if (I_WB_SEL[0])
        high_th_ff[7:0] <= I_WB_DAT[7:0];
      if (I_WB_SEL[1])
        high_th_ff[15:8] <= I_WB_DAT[15:8];
      // (R15) six-bit hysteresis
      if (I_WB_SEL[3])
        hyst_ff <= I_WB_DAT[`APMC_HYST_MSB:`APMC_HYST_LSB];
    end
    else if (I_CE && bus_wr && bus_idx == `APMC_IDX_ALARM_L_TH)
    begin
      if (I_WB_SEL[0])
        low_th_ff[7:0] <= I_WB_DAT[7:0];
      if (I_WB_SEL[1])
        low_th_ff[15:8] <= I_WB_DAT[15:8];
    end
  end

  // =====================================================================
  // Power sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      apmc_pkg::ST_ACTIVE:
        // (R6) deep request on rising edge
        if (pin_rise && deep_req_ff)
          nxt_state = apmc_pkg::ST_DEEP;
        else if (pin_rise)
          nxt_state = apmc_pkg::ST_CONVERT;
      apmc_pkg::ST_CONVERT:
        // (R3) light sleep at end of conversion
        if (I_CONV_DONE && light_en_ff && I_CONVERT_SELECT)
          nxt_state = apmc_pkg::ST_LIGHT;
        else if (I_CONV_DONE)
          nxt_state = apmc_pkg::ST_ACTIVE;
      apmc_pkg::ST_LIGHT:
        // (R4) falling edge wakes
        if (pin_fall)
          nxt_state = apmc_pkg::ST_LIGHT_WAKE;
      apmc_pkg::ST_LIGHT_WAKE:
        if (wait_ff == 24'h00_0000)
          nxt_state = apmc_pkg::ST_ACTIVE;
      apmc_pkg::ST_DEEP:
        // (R9) request cleared by host
        if (!deep_req_ff)
          nxt_state = apmc_pkg::ST_DEEP_WAKE;
      apmc_pkg::ST_DEEP_WAKE:
        if (wait_ff == 24'h00_0000)
          nxt_state = apmc_pkg::ST_ACTIVE;
      default: nxt_state = apmc_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_ff <= apmc_pkg::ST_ACTIVE;
      pin_prev_ff <= 1'b0;
    end
    else if (I_CE)
    begin
      state_ff <= nxt_state;
      pin_prev_ff <= I_CONVERT_SELECT;
    end
  end

  // Wake-up counters; edges arriving before they expire are dropped
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      wait_ff <= 24'h00_0000;
    else if (I_CE)
    begin
      // (R5) light wake time
      if (state_ff == apmc_pkg::ST_LIGHT && nxt_state == apmc_pkg::ST_LIGHT_WAKE)
        wait_ff <= {16'h0000, LIGHT_WAKE_CYC - 8'h01};
      // (R11) deep wake time
      else if (state_ff == apmc_pkg::ST_DEEP && nxt_state == apmc_pkg::ST_DEEP_WAKE)
        wait_ff <= 24'(DEEP_WAKE_CYC - 1);
      else if (wait_ff != 24'h00_0000)
        wait_ff <= wait_ff - 24'h00_0001;
    end
  end

  // =====================================================================
  // Power and ready outputs
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_CONV_START <= 1'b0;
      O_ANALOG_PWR_EN <= 1'b1;
      O_LOW_POWER <= 1'b0;
      O_READY_IND <= 1'b1;
    end
    else if (I_CE)
    begin
      O_CONV_START <= (state_ff == apmc_pkg::ST_ACTIVE) && (nxt_state == apmc_pkg::ST_CONVERT);
      // (R1) powered between conversions
      // (R7) analog off in deep sleep
      O_ANALOG_PWR_EN <= (nxt_state != apmc_pkg::ST_DEEP);
      O_LOW_POWER <= (nxt_state == apmc_pkg::ST_LIGHT);
      // (R8) ready in deep sleep
      // (R10) ready as power-up begins
      O_READY_IND <= (nxt_state != apmc_pkg::ST_CONVERT);
    end
  end

  // =====================================================================
  // Alarm evaluation
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      active_ff <= '0;
    else if (I_CE)
    begin
      // (R14) supply alarm
      active_ff.sup_low <= I_SUPPLY_LOW;
      active_ff.sup_high <= I_SUPPLY_HIGH;
      if (I_CONV_DONE && state_ff == apmc_pkg::ST_CONVERT)
      begin
        // (R12) outside window trips
        // (R13) hysteresis on release
        // (R17) release points
        if (!active_ff.in_high)
          active_ff.in_high <= (I_RESULT > high_th_ff);
        else
          active_ff.in_high <= !({1'b0, I_RESULT} < sat_sub(high_th_ff, hyst_ff));
        if (!active_ff.in_low)
          active_ff.in_low <= (I_RESULT < low_th_ff);
        else
          active_ff.in_low <= !({1'b0, I_RESULT} > sat_add(low_th_ff, hyst_ff));
      end
    end
  end

  // Tripped flags are sticky and clear on a status read; a new trip wins
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      trip_ff <= '0;
    else if (I_CE)
      trip_ff <= (stat_rd ? 4'h0 : trip_ff) | active_ff;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      O_ALARM <= 1'b0;
    // (R16) OR of tripped flags
    else if (I_CE)
      O_ALARM <= |((stat_rd ? 4'h0 : trip_ff) | active_ff);
  end

endmodule

`default_nettype wire

/* File: src/apmc_defines.svh */
/*
  Offsets, field positions, reset values and timing counts of the converter
  power mode and alarm controller. Assumes a 32-bit classic Wishbone slave
  with word-aligned registers and a 10 MHz core clock.
*/
`ifndef APMC_DEFINES_SVH
`define APMC_DEFINES_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define APMC_IDX_PWRCTL      8'h04
`define APMC_IDX_UNLOCK      8'h05
`define APMC_IDX_STATUS      8'h20
`define APMC_IDX_ALARM_H_TH  8'h24
`define APMC_IDX_ALARM_L_TH  8'h28
`define APMC_UNLOCK_KEY      8'h69

// =====================================================================
// Field positions
`define APMC_PWR_DEEP_BIT    0
`define APMC_PWR_LIGHT_BIT   1
`define APMC_HYST_LSB        26
`define APMC_HYST_MSB        31

// =====================================================================
// Reset values
`define APMC_RST_HIGH_TH     16'hFFFF
`define APMC_RST_LOW_TH      16'h0000
`define APMC_RST_HYST        6'h00

// =====================================================================
// Timing
`define APMC_CLK_PERIOD_NS   100
`define APMC_LIGHT_WAKE_NS   20000
`define APMC_LIGHT_WAKE_CYC  ((`APMC_LIGHT_WAKE_NS + `APMC_CLK_PERIOD_NS - 1) / `APMC_CLK_PERIOD_NS)
`define APMC_DEEP_WAKE_NS    10000000
`define APMC_DEEP_WAKE_CYC   ((`APMC_DEEP_WAKE_NS + `APMC_CLK_PERIOD_NS - 1) / `APMC_CLK_PERIOD_NS)

`endif

/* File: src/apmc_pkg.sv */
/*
  Types of the converter power mode and alarm controller.
  Assumes apmc_defines.svh for all numeric constants.
*/
package apmc_pkg;

  // =====================================================================
  // Power sequencer states
  typedef enum logic [2:0] {
    ST_ACTIVE     = 3'b000,
    ST_CONVERT    = 3'b001,
    ST_LIGHT      = 3'b010,
    ST_LIGHT_WAKE = 3'b011,
    ST_DEEP       = 3'b100,
    ST_DEEP_WAKE  = 3'b101
  } apmc_state_e;

  // =====================================================================
  // Alarm flag group: high and low for the input and the supply
  typedef struct packed {
    logic sup_low;
    logic sup_high;
    logic in_low;
    logic in_high;
  } apmc_flags_s;

endpackage

/* File: dv/apmc_core_model.sv */
/*
  Converter core partner: answers a conversion start with a done pulse.
  Assumes start is a one-cycle pulse on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module apmc_core_model (
  // Clock and request
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic i_slow,
  input wire logic [15:0] i_val,
  // Answer
  output logic o_done = 1'b0,
  output logic [15:0] o_res = 16'h0000
);
  int n = 0;
  logic [15:0] last = 16'h0000;
  // =====================================================================
  // Result bus shows the inverse of the last value outside done
  always @(posedge i_clk)
  begin
    o_done <= 1'b0;
    o_res <= ~last;
    if (i_start)
      n <= i_slow ? 9 : 2;
    else if (n > 1)
      n <= n - 1;
    else if (n == 1)
    begin
      n <= 0;
      o_done <= 1'b1;
      o_res <= i_val;
      last <= i_val;
    end
  end
endmodule
`default_nettype wire

/* File: dv/apmc_props.sv */
/*
  Checker on the ports of apmc_top, bound below.
  Assumes I_CE high whenever the bus is used.
*/
`timescale 1ns/1ps
`default_nettype none
module apmc_props (
  // Clock, reset, bus
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic O_WB_ACK,
  // Pins
  input wire logic I_CONVERT_SELECT,
  input wire logic I_SUPPLY_LOW,
  input wire logic O_CONV_START,
  input wire logic O_ANALOG_PWR_EN,
  input wire logic O_LOW_POWER,
  input wire logic O_READY_IND,
  input wire logic O_ALARM
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // =====================================================================
  // Sequencer
  chk_start_edge: assert property ($rose(O_CONV_START) |-> O_ANALOG_PWR_EN &&
    $past(I_CONVERT_SELECT) && !$past(I_CONVERT_SELECT, 2)) else $error("start without pin rise");
  chk_light_hold: assert property (O_LOW_POWER && I_CONVERT_SELECT |=> O_LOW_POWER)
    else $error("light sleep left with pin high");
  chk_light_exit: assert property (O_LOW_POWER && $fell(I_CONVERT_SELECT) |=> !O_LOW_POWER)
    else $error("light sleep kept after pin fall");
  chk_wake_quiet: assert property ($fell(O_LOW_POWER) |=> !O_CONV_START [*8])
    else $error("start during light wake");
  chk_deep_entry: assert property ($fell(O_ANALOG_PWR_EN) |->
    $past(I_CONVERT_SELECT) && !$past(I_CONVERT_SELECT, 2)) else $error("deep entry without pin rise");
  chk_deep_ready: assert property (!O_ANALOG_PWR_EN |-> O_READY_IND && !O_CONV_START)
    else $error("ready low in deep sleep");
  chk_wake_ready: assert property ($rose(O_ANALOG_PWR_EN) |-> O_READY_IND)
    else $error("ready low at power-up");
  chk_bus_alive: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("bus not answered");
  // =====================================================================
  // Alarm
  chk_sup_alarm: assert property ($rose(I_SUPPLY_LOW) |-> ##[1:4] O_ALARM)
    else $error("supply alarm missing");
  chk_alarm_hold: assert property (O_ALARM && !I_WB_STB && !$past(I_WB_STB) &&
    !$past(I_WB_STB, 2) |=> O_ALARM) else $error("alarm cleared without read");
endmodule
bind apmc_top apmc_props i_apmc_props (.I_CLK(I_CLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .I_CONVERT_SELECT(I_CONVERT_SELECT),
  .I_SUPPLY_LOW(I_SUPPLY_LOW), .O_CONV_START(O_CONV_START), .O_ANALOG_PWR_EN(O_ANALOG_PWR_EN),
  .O_LOW_POWER(O_LOW_POWER), .O_READY_IND(O_READY_IND), .O_ALARM(O_ALARM));
`default_nettype wire

/* File: dv/apmc_tb_top.sv */
/*
  Self-checking bench for apmc_top with a model of flags and registers.
  Assumes the core partner model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module apmc_tb_top;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pin = 0, sl = 0, sh = 0, slow = 0, ce = 1;
  logic ack, lp, pw, rdy, alm, cs, dn;
  logic [9:0] adr = 0;
  logic [31:0] wd = 0, rd;
  logic [15:0] res, val = 0;
  logic [3:0] act = 0, trp = 0;
  int failures = 0, comparisons = 0, seed = 32'hf473_aa09, hi = 65535, lo = 0, hy = 0;
  int tv[8] = '{2000, 998, 990, 50, 102, 200, 0, 0};
  always #50 clk = ~clk;
  apmc_top #(.DEEP_WAKE_CYC(20)) i_apmc_top (.I_CLK(clk), .I_RST(rst), .I_CE(ce),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf),
    .I_WB_DAT(wd), .O_WB_DAT(rd), .O_WB_ACK(ack), .I_CONVERT_SELECT(pin), .I_CONV_DONE(dn),
    .I_RESULT(res), .I_SUPPLY_LOW(sl), .I_SUPPLY_HIGH(sh), .O_CONV_START(cs),
    .O_ANALOG_PWR_EN(pw), .O_LOW_POWER(lp), .O_READY_IND(rdy), .O_ALARM(alm));
  apmc_core_model i_apmc_core_model (.i_clk(clk), .i_start(cs), .i_slow(slow), .i_val(val),
    .o_done(dn), .o_res(res));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("FAIL %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input logic v);
    int t = 0;
    while (rdy !== v && t < 300)
    begin
      @(posedge clk);
      t++;
    end
    chk("wait", rdy, v);
  endtask
  // =====================================================================
  // Classic single cycle, held until ack is sampled
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++t < 50);
    chk("ack", ack, 1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task rdst();
    bus(0, 10'h080, 0);
    chk("status", rd, {16'h0, act[3:2], 2'b00, act[1:0], 2'b00, trp, 3'b000, |trp});
    trp = act;
  endtask
  task conv(input int r, input logic keep);
    val <= r[15:0];
    slow <= 1'($random(seed));
    @(posedge clk) pin <= 1;
    wt(0);
    wt(1);
    if (r > hi) act[0] = 1; else if (r < hi - hy) act[0] = 0;
    if (r < lo) act[1] = 1; else if (r > lo + hy) act[1] = 0;
    trp |= act;
    repeat (3) @(posedge clk);
    chk("alarm", alm, |trp);
    if (!keep) pin <= 0;
    repeat (2) @(posedge clk);
  endtask
  task complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #2000000;
    failures++;
    complete_run();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    bus(0, 10'h090, 0); chk("high_th", rd, 32'h0000_ffff);
    bus(0, 10'h0fc, 0); chk("unmapped", rd, 0);
    chk("ready", rdy, 1);
    // Enable low: a pin rise must not start anything
    ce <= 0;
    pin <= 1;
    repeat (3) @(posedge clk);
    chk("frozen", rdy, 1);
    pin <= 0;
    ce <= 1;
    $display("reset test done");
    bus(1, 10'h010, 2); bus(0, 10'h010, 0); chk("locked", rd, 0);
    bus(1, 10'h014, 32'h69); bus(1, 10'h010, 2); bus(0, 10'h010, 0); chk("pwrctl", rd, 2);
    conv(500, 1); chk("light", lp, 1);
    repeat (5) @(posedge clk); chk("light_hold", lp, 1);
    pin <= 0; repeat (2) @(posedge clk); chk("light_exit", lp, 0);
    repeat (201) @(posedge clk);
    $display("light sleep test done");
    bus(1, 10'h010, 0); bus(1, 10'h090, 32'h1303_03e8); bus(1, 10'h0a0, 100);
    hi = 1000; hy = 4; lo = 100;
    bus(0, 10'h090, 0); chk("hyst", rd, 32'h1000_03e8);
    foreach (tv[i])
    begin
      conv(i < 6 ? tv[i] : $random(seed) & 16'hffff, 0);
      rdst();
    end
    sl <= 1; repeat (4) @(posedge clk); chk("sup_alarm", alm, 1);
    act[3] = 1; trp[3] = 1; rdst();
    sl <= 0; repeat (3) @(posedge clk); act[3] = 0; rdst();
    $display("alarm test done");
    bus(1, 10'h010, 1); @(posedge clk) pin <= 1;
    repeat (3) @(posedge clk); chk("deep_pwr", pw, 0);
    chk("deep_ready", rdy, 1);
    bus(0, 10'h0a0, 0); chk("retained", rd, 100);
    pin <= 0; bus(1, 10'h010, 0); chk("wake_ready", rdy, 1);
    repeat (25) @(posedge clk); chk("wake_pwr", pw, 1);
    conv(300, 0);
    bus(1, 10'h014, 0); bus(1, 10'h010, 2); bus(0, 10'h010, 0); chk("relock", rd, 0);
    $display("deep sleep test done");
    complete_run();
  end
endmodule
`default_nettype wire
